// ==== core/fpsc_fan_ctrl.sv ====
// two-channel fan pwm speed controller with its three runtime registers
// How it works
// RULE1 - a set force-high bit holds that fan output high whatever the duty.
// RULE2 - with force-high clear the output duty comes from the duty code.
// RULE3 - a duty code of zero keeps the output low with no pulses.
// RULE4 - a duty code of 63 gives high for 63 slots and low for one slot.
// RULE5 - the duty code sits in bits 6..1 and high time is code/64 of period.
// RULE6 - undoubled, source 0 gives 15.625 or 23.438 kHz, source 1 40 or 60 Hz.
// RULE7 - the doubling bit doubles the selected output frequency.
// RULE8 - config bits 1..0 pick each source and bits 3..2 each doubling.
// RULE9 - config bits 7..6 and 5..4 hold a per-channel tach divisor field.
// RULE10 - the fan registers decode at 0x56, 0x57 and config at 0x58.
// RULE11 - after reset both fan outputs are driven low.
// RULE12 - each channel runs 64 slots per period and takes changes at the end.
// RULE13 - all three registers are read/write and read back what was written.
`timescale 1ns/1ps
module fpsc_fan_ctrl #(
  parameter int DIV_W = 16,
  parameter int FAST_LO_DIV = fpsc_pkg::FAST_LO_DIV,
  parameter int FAST_HI_DIV = fpsc_pkg::FAST_HI_DIV,
  parameter int SLOW_LO_DIV = fpsc_pkg::SLOW_LO_DIV,
  parameter int SLOW_HI_DIV = fpsc_pkg::SLOW_HI_DIV
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // runtime register port
  input wire logic [7:0] regAddr,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  // fan pins
  output logic first_fan_drive_out,
  output logic second_fan_drive_out
);
  initial begin
    if (SLOW_LO_DIV >= (1 << DIV_W) || SLOW_HI_DIV >= (1 << DIV_W) ||
        FAST_LO_DIV >= (1 << DIV_W) || FAST_HI_DIV >= (1 << DIV_W))
      $error("fpsc_fan_ctrl: divisor does not fit DIV_W");
    if (FAST_LO_DIV < 2 || FAST_HI_DIV < 2 || SLOW_LO_DIV < 2 ||
        SLOW_HI_DIV < 2)
      $error("fpsc_fan_ctrl: divisor too small to double");
  end

  logic [7:0] fanReg [2];
  logic [7:0] next_fanReg [2];
  logic [7:0] fanRateConfig, next_fanRateConfig;
  logic [7:0] next_regRdData;
  logic [1:0] chanOut;
  logic [DIV_W-1:0] chanDiv [2];
  logic [1:0] tachDivSel [2];

  // register writes; address decode by exact offset
  always_comb begin
    next_fanReg = fanReg;
    next_fanRateConfig = fanRateConfig;
    if (regWr) begin
      case (regAddr) // RULE10
        fpsc_pkg::FIRST_FAN_OFS: next_fanReg[0] = regWrData;
        fpsc_pkg::SECOND_FAN_OFS: next_fanReg[1] = regWrData;
        fpsc_pkg::RATE_CFG_OFS: next_fanRateConfig = regWrData;
        default: next_fanRateConfig = fanRateConfig;
      endcase
    end
  end

  // reads return stored values; unmapped offsets read as zero
  always_comb begin
    next_regRdData = regRdData;
    if (regRd) begin
      case (regAddr) // RULE13
        fpsc_pkg::FIRST_FAN_OFS: next_regRdData = fanReg[0];
        fpsc_pkg::SECOND_FAN_OFS: next_regRdData = fanReg[1];
        fpsc_pkg::RATE_CFG_OFS: next_regRdData = fanRateConfig;
        default: next_regRdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      fanReg[0] <= fpsc_pkg::FAN_REG_RST;
      fanReg[1] <= fpsc_pkg::FAN_REG_RST;
      fanRateConfig <= fpsc_pkg::RATE_CFG_RST;
      regRdData <= 8'h00;
    end else begin
      fanReg <= next_fanReg;
      fanRateConfig <= next_fanRateConfig;
      regRdData <= next_regRdData;
    end
  end

  // per channel: pick slot divisor, halve it when doubled
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic srcSlow;
    logic rateHi;
    logic dbl;
    logic [DIV_W-1:0] baseDiv;
    assign srcSlow = fanRateConfig[fpsc_pkg::SRC_SEL_BIT + ch]; // RULE8
    assign dbl = fanRateConfig[fpsc_pkg::DOUBLE_BIT + ch]; // RULE8
    assign rateHi = fanReg[ch][fpsc_pkg::RATE_SEL_BIT];
    // tach divisor is stored only; tach counting lives elsewhere
    assign tachDivSel[ch] =
      fanRateConfig[fpsc_pkg::TACH_DIV_LSB + 2*ch +: 2]; // RULE9
    always_comb begin
      case ({srcSlow, rateHi}) // RULE6
        2'b00: baseDiv = DIV_W'(FAST_LO_DIV);
        2'b01: baseDiv = DIV_W'(FAST_HI_DIV);
        2'b10: baseDiv = DIV_W'(SLOW_LO_DIV);
        2'b11: baseDiv = DIV_W'(SLOW_HI_DIV);
        default: baseDiv = DIV_W'(FAST_LO_DIV);
      endcase
    end
    // halving the slot length doubles the rate; odd counts round down
    assign chanDiv[ch] = dbl ? (baseDiv >> 1) : baseDiv; // RULE7

    fpsc_pwm_channel #(
      .DIV_W(DIV_W)
    ) u_chan (
      .core_clk(core_clk),
      .srst(srst),
      .slotDiv(chanDiv[ch]),
      .dutyCode(fanReg[ch][fpsc_pkg::DUTY_MSB:fpsc_pkg::DUTY_LSB]),
      .forceHigh(fanReg[ch][fpsc_pkg::FORCE_BIT]),
      .pwmWaveform(chanOut[ch])
    );
  end

  assign first_fan_drive_out = chanOut[0];
  assign second_fan_drive_out = chanOut[1];

  default clocking cb @(posedge core_clk); endclocking

  sequence writeFirst;
    regWr && regAddr == fpsc_pkg::FIRST_FAN_OFS;
  endsequence
  sequence readFirst;
    regRd && !regWr && regAddr == fpsc_pkg::FIRST_FAN_OFS;
  endsequence

  AST_RESET_LOW: assert property ( // RULE11
    @(posedge core_clk) srst |=> !first_fan_drive_out &&
    !second_fan_drive_out)
    else $error("fan outputs not low after reset");
  AST_READBACK: assert property ( // RULE13
    @(posedge core_clk) disable iff (srst)
    (writeFirst ##1 readFirst) |=> regRdData == $past(regWrData, 2))
    else $error("first fan register readback wrong");
  AST_CFG_DECODE: assert property ( // RULE10
    @(posedge core_clk) disable iff (srst)
    regWr && regAddr == fpsc_pkg::RATE_CFG_OFS |=>
    fanRateConfig == $past(regWrData) && $stable(fanReg[0]))
    else $error("config register decode wrong");
  AST_UNMAPPED_ZERO: assert property ( // RULE10
    @(posedge core_clk) disable iff (srst)
    regRd && regAddr > fpsc_pkg::RATE_CFG_OFS |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  AST_SLOW_DOUBLED: assert property ( // RULE7
    @(posedge core_clk) disable iff (srst)
    fanRateConfig[0] && fanRateConfig[2] && fanReg[0][7] |->
    chanDiv[0] == DIV_W'(SLOW_HI_DIV / 2))
    else $error("doubled slow divisor wrong");
  AST_FAST_PLAIN: assert property ( // RULE6
    @(posedge core_clk) disable iff (srst)
    !fanRateConfig[1] && !fanRateConfig[3] && !fanReg[1][7] |->
    chanDiv[1] == DIV_W'(FAST_LO_DIV))
    else $error("undoubled fast divisor wrong");
  AST_TACH_FIELD: assert property ( // RULE9
    @(posedge core_clk) disable iff (srst)
    tachDivSel[1] == fanRateConfig[7:6])
    else $error("tach divisor field misplaced");
endmodule // fpsc_fan_ctrl

// ==== core/fpsc_pkg.sv ====
// shared constants for the two-channel fan pwm speed controller
package fpsc_pkg;
  // register offsets in the runtime block
  localparam logic [7:0] FIRST_FAN_OFS = 8'h56;
  localparam logic [7:0] SECOND_FAN_OFS = 8'h57;
  localparam logic [7:0] RATE_CFG_OFS = 8'h58;
  // reset values of the three registers
  localparam logic [7:0] FAN_REG_RST = 8'h00;
  localparam logic [7:0] RATE_CFG_RST = 8'h00;
  // per-fan register fields
  localparam int FORCE_BIT = 0;
  localparam int DUTY_LSB = 1;
  localparam int DUTY_MSB = 6;
  localparam int RATE_SEL_BIT = 7;
  // shared config fields, channel index (twice it for the tach field) added to the base bit
  localparam int SRC_SEL_BIT = 0;
  localparam int DOUBLE_BIT = 2;
  localparam int TACH_DIV_LSB = 4;
  // slots in one output period
  localparam int SLOTS = 64;
  // timing: core clock and output rates, in millihertz
  localparam longint CLK_MHZ = 64'd25_000_000_000;
  localparam longint FAST_LO_MHZ = 64'd15_625_000;
  localparam longint FAST_HI_MHZ = 64'd23_438_000;
  localparam longint SLOW_LO_MHZ = 64'd40_000;
  localparam longint SLOW_HI_MHZ = 64'd60_000;
  // core cycles per slot, rounded to the nearest whole cycle
  localparam int FAST_LO_DIV =
    int'((CLK_MHZ + FAST_LO_MHZ * SLOTS / 2) / (FAST_LO_MHZ * SLOTS));
  localparam int FAST_HI_DIV =
    int'((CLK_MHZ + FAST_HI_MHZ * SLOTS / 2) / (FAST_HI_MHZ * SLOTS));
  localparam int SLOW_LO_DIV =
    int'((CLK_MHZ + SLOW_LO_MHZ * SLOTS / 2) / (SLOW_LO_MHZ * SLOTS));
  localparam int SLOW_HI_DIV =
    int'((CLK_MHZ + SLOW_HI_MHZ * SLOTS / 2) / (SLOW_HI_MHZ * SLOTS));
endpackage

// ==== core/fpsc_pwm_channel.sv ====
// one pwm channel: slot prescaler, 64-slot period counter, output
`timescale 1ns/1ps
module fpsc_pwm_channel #(
  parameter int DIV_W = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // settings from the register file
  input wire logic [DIV_W-1:0] slotDiv,
  input wire logic [5:0] dutyCode,
  input wire logic forceHigh,
  // pin
  output logic pwmWaveform
);
  initial begin
    if (DIV_W < 2 || DIV_W > 32) $error("fpsc_pwm_channel: bad DIV_W");
  end

  logic [DIV_W-1:0] preCnt, next_preCnt;
  logic [5:0] slot, next_slot;
  logic [5:0] curDuty, next_curDuty;
  logic curForce, next_curForce;
  logic [DIV_W-1:0] curDiv, next_curDiv;
  logic next_pwmWaveform;
  logic slotTick;
  logic periodEnd;

  // a zero divisor is served as one cycle per slot
  assign slotTick = (preCnt + DIV_W'(1) >= curDiv);
  assign periodEnd = slotTick && (slot == 6'h3F);

  // settings are only taken at the period boundary so no runt pulse
  always_comb begin
    next_preCnt = slotTick ? '0 : preCnt + DIV_W'(1);
    next_slot = slotTick ? slot + 6'h01 : slot;
    next_curDuty = curDuty;
    next_curForce = curForce;
    next_curDiv = curDiv;
    if (periodEnd) begin // RULE12
      next_curDuty = dutyCode;
      next_curForce = forceHigh;
      next_curDiv = slotDiv;
    end
    if (curForce) begin
      next_pwmWaveform = 1'b1; // RULE1
    end else begin
      // code 0 never high, code 63 misses only slot 63
      next_pwmWaveform = (slot < curDuty); // RULE2 RULE3 RULE4 RULE5
    end
  end

  // registers; output comes up low
  always_ff @(posedge core_clk) begin
    if (srst) begin
      preCnt <= '0;
      slot <= 6'h00;
      curDuty <= 6'h00;
      curForce <= 1'b0;
      curDiv <= '0;
      pwmWaveform <= 1'b0; // RULE11
    end else begin
      preCnt <= next_preCnt;
      slot <= next_slot;
      curDuty <= next_curDuty;
      curForce <= next_curForce;
      curDiv <= next_curDiv;
      pwmWaveform <= next_pwmWaveform;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence midPeriod;
    !periodEnd;
  endsequence

  AST_FORCE_HIGH: assert property ( // RULE1
    curForce |=> pwmWaveform)
    else $error("forced channel output not high");
  AST_DUTY_FOLLOWS: assert property ( // RULE2
    !curForce |=> pwmWaveform == ($past(slot) < $past(curDuty)))
    else $error("output does not follow duty code");
  AST_ZERO_LOW: assert property ( // RULE3
    ((!curForce && curDuty == 6'h00) and midPeriod) |=> !pwmWaveform)
    else $error("zero duty produced a pulse");
  AST_FULL_ONE_LOW: assert property ( // RULE4
    !curForce && curDuty == 6'h3F && slot == 6'h3F ##1 midPeriod
    |-> !pwmWaveform)
    else $error("full duty missing its low slot");
  AST_DUTY_HOLD: assert property ( // RULE12
    midPeriod |=> $stable(curDuty) && $stable(curForce))
    else $error("settings changed inside a period");
  AST_SLOT_PACE: assert property ( // RULE5
    !slotTick |=> $stable(slot))
    else $error("slot moved without a tick");
endmodule // fpsc_pwm_channel

// ==== sim/fpsc_fan_model.sv ====
// fan model: measures high time and period of its pwm input
`timescale 1ns/1ps
module fpsc_fan_model (
  // clock
  input wire logic core_clk,
  // pwm drive from the controller
  input wire logic pwmIn,
  // last full period seen, in core cycles
  output logic [15:0] highCnt,
  output logic [15:0] periodCnt
);
  logic prevIn = 1'b0;
  logic [15:0] hiAcc = 16'h0000;
  logic [15:0] perAcc = 16'h0000;
  // a fan only sees edges, so measure from rise to rise
  always @(posedge core_clk) begin
    prevIn <= pwmIn;
    if (pwmIn && !prevIn) begin
      highCnt <= hiAcc;
      periodCnt <= perAcc;
      hiAcc <= 16'h0001;
      perAcc <= 16'h0001;
    end else begin
      hiAcc <= hiAcc + {15'h0000, pwmIn};
      perAcc <= perAcc + 16'h0001;
    end
  end
endmodule // fpsc_fan_model

// ==== sim/fpsc_fan_ctrl_tb.sv ====
// self-checking bench for the fan pwm speed controller
`timescale 1ns/1ps
module fpsc_fan_ctrl_tb;
  // slow rates shortened so a run stays short
  localparam int SLO = 20;
  localparam int SHI = 14;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regWrData = 8'h00;
  logic [7:0] regRdData;
  logic [1:0] fanOut;
  logic [15:0] hiCnt [2];
  logic [15:0] perCnt [2];
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;

  fpsc_fan_ctrl #(.SLOW_LO_DIV(SLO), .SLOW_HI_DIV(SHI)) fpsc_fan_ctrl_inst (
    .core_clk(core_clk), .srst(srst), .regAddr(regAddr),
    .regWr(regWr), .regRd(regRd), .regWrData(regWrData),
    .regRdData(regRdData), .first_fan_drive_out(fanOut[0]),
    .second_fan_drive_out(fanOut[1]));
  // one fan on each drive pin
  for (genvar i = 0; i < 2; i++) begin : gFan
    fpsc_fan_model fpsc_fan_model_inst (.core_clk(core_clk),
      .pwmIn(fanOut[i]), .highCnt(hiCnt[i]), .periodCnt(perCnt[i]));
  end

  // 25 MHz clock
  initial begin
    forever #20 core_clk = ~core_clk;
  end

  task automatic end_sim();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // hang guard, well above the planned 57k cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 75000) begin
      failures++;
      end_sim();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1 regAddr = a;
    regWrData = d;
    regWr = 1'b1;
    @(posedge core_clk);
    #1 regWr = 1'b0;
  endtask

  // data stands until the next read, so look one edge late
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    #1 regAddr = a;
    regRd = 1'b1;
    @(posedge core_clk);
    #1 regRd = 1'b0;
    @(posedge core_clk);
    #1 chk({8'h00, regRdData}, {8'h00, exp});
  endtask

  // write, then read the same place in the very next cycle
  task automatic wrrd(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1 regAddr = a;
    regWrData = d;
    regWr = 1'b1;
    @(posedge core_clk);
    #1 regWr = 1'b0;
    regRd = 1'b1;
    @(posedge core_clk);
    #1 regRd = 1'b0;
    chk({8'h00, regRdData}, {8'h00, d});
  endtask

  // core cycles per slot for one mode
  function automatic int slotDiv(logic src, logic rate, logic dbl);
    int d;
    d = src ? (rate ? SHI : SLO) :
      (rate ? fpsc_pkg::FAST_HI_DIV : fpsc_pkg::FAST_LO_DIV);
    return dbl ? d / 2 : d;
  endfunction

  initial begin
    logic [7:0] v [3];
    logic [5:0] duty [2];
    logic [2:0] md [2];
    int d;
    void'($urandom(19813));
    repeat (8) @(posedge core_clk);
    #1 srst = 1'b0;
    chk({14'h0000, fanOut}, 16'h0000);
    for (int k = 0; k < 3; k++) begin
      rd(8'h56 + 8'(k), 8'h00);
    end
    // back to back writes, then reads, then unmapped places
    for (int k = 0; k < 3; k++) begin
      v[k] = 8'($urandom);
      wr(8'h56 + 8'(k), v[k]);
    end
    wr(8'h59, 8'($urandom));
    for (int k = 0; k < 3; k++) begin
      rd(8'h56 + 8'(k), v[k]);
    end
    rd(8'h59, 8'h00);
    rd(8'h55, 8'h00);
    wrrd(8'h56, 8'($urandom));
    // every rate mode on each channel, random duty with the extremes
    for (int m = 0; m < 8; m++) begin
      md[0] = 3'(m);
      md[1] = 3'(7 - m);
      for (int c = 0; c < 2; c++) begin
        duty[c] = 6'($urandom_range(63, 1));
      end
      if (m == 0) begin
        duty[0] = 6'h3F;
        duty[1] = 6'h01;
      end
      wr(8'h56, {md[0][1], duty[0], 1'b0});
      wr(8'h57, {md[1][1], duty[1], 1'b0});
      wr(8'h58, {4'($urandom), md[1][2], md[0][2], md[1][0], md[0][0]});
      repeat (6400) @(posedge core_clk);
      #1;
      for (int c = 0; c < 2; c++) begin
        d = slotDiv(md[c][0], md[c][1], md[c][2]);
        chk(perCnt[c], 16'(64 * d));
        chk(hiCnt[c], 16'(int'(duty[c]) * d));
      end
    end
    // zero duty stays low, force holds high whatever the duty
    wr(8'h56, 8'h80);
    wr(8'h57, {1'b0, 6'($urandom), 1'b1});
    repeat (3300) @(posedge core_clk);
    repeat (2000) begin
      @(posedge core_clk);
      #1 chk({14'h0000, fanOut}, 16'h0002);
    end
    end_sim();
  end
endmodule // fpsc_fan_ctrl_tb
